// ===== inc/sdalu_pkg.sv
// Shared constants and types for the saturating DSP arithmetic datapath.
// Assumes a single processor clock; no architectural state is held here.
package sdalu_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int DEST_W = 7;
  localparam int LATENCY = 2;
  localparam int GUARD_BIT = 0;

  // ---------------------------------------------------------------
  // Clip limits and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] WORD_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] WORD_MIN = 32'h80000000;
  localparam logic [15:0] HALF_MAX = 16'h7FFF;
  localparam logic [15:0] HALF_MIN = 16'h8000;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  localparam logic [6:0] DEST_RST = 7'h00;

  // ---------------------------------------------------------------
  // Operation select
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WORD_ABS = 2'b00,
    OP_WORD_ADD = 2'b01,
    OP_DUAL_ABS = 2'b10,
    OP_DUAL_ADD = 2'b11
  } sdalu_op_t;

endpackage : sdalu_pkg

// ===== src/sdalu_lane.sv
// One saturating lane: clipped signed add, or clipped absolute value of
// the difference second minus first. Purely combinational.
// Assumes the caller registers inputs and output around it.
`timescale 1ns/100ps
module sdalu_lane #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic abs_i,
  output logic [W-1:0] res_o
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (W < 2) begin : g_bad_w
    $error("sdalu_lane: lane width must be at least 2");
  end

  localparam logic signed [W+1:0] LIM_MAX = {3'b000, {(W-1){1'b1}}};
  localparam logic signed [W+1:0] LIM_MIN = {3'b111, {(W-1){1'b0}}};

  logic signed [W+1:0] ext_a;
  logic signed [W+1:0] ext_b;
  logic signed [W+1:0] raw;
  logic signed [W+1:0] mag;

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  // Two guard bits keep the negation of the most negative value exact
  always_comb begin
    ext_a = {{2{a_i[W-1]}}, a_i};
    ext_b = {{2{b_i[W-1]}}, b_i};
    if (abs_i) begin
      raw = ext_b - ext_a;
      mag = raw[W+1] ? -raw : raw;
    end else begin
      raw = ext_a + ext_b;
      mag = raw;
    end
    if (mag > LIM_MAX) begin
      res_o = LIM_MAX[W-1:0];
    end else if (mag < LIM_MIN) begin
      res_o = LIM_MIN[W-1:0];
    end else begin
      res_o = mag[W-1:0];
    end
  end

endmodule : sdalu_lane

// ===== src/sdalu_top.sv
// Saturating DSP arithmetic unit: word abs, word add, dual half abs and
// dual half add, each clipped and optionally guarded.
// Assumes issue logic presents one operation per cycle at most and that
// the register file performs the write when res_wr_en_o is high.
//
// Function
// - Word abs passes non-negative source, negates negative source.
// - Word abs of most negative word gives largest positive word.
// - Word abs runs as two-operand abs with first operand zero.
// - Word add clips sums above largest positive word to it.
// - Word add clips sums below most negative word; in-range unchanged.
// - Dual abs takes each half's magnitude, clipped to 0..0x7FFF.
// - Dual abs of half 0x8000 gives 0x7FFF in that half.
// - Dual abs runs as two-operand abs with first operand zero.
// - Dual add sums halves separately, clipping below to 0x8000.
// - Dual add clips above to 0x7FFF; low to 15:0, high 31:16.
// - Guarded operation writes only when guard bit 0 is one.
`timescale 1ns/100ps
module sdalu_top #(
  parameter int DATA_W = sdalu_pkg::WORD_W
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic op_valid_i,
  input wire logic [1:0] op_code_i,
  input wire logic [DATA_W-1:0] first_source_i,
  input wire logic [DATA_W-1:0] second_source_i,
  input wire logic guard_used_i,
  input wire logic [DATA_W-1:0] guard_value_i,
  input wire logic [sdalu_pkg::DEST_W-1:0] dest_sel_i,
  output logic res_valid_o,
  output logic res_wr_en_o,
  output logic [DATA_W-1:0] res_data_o,
  output logic [sdalu_pkg::DEST_W-1:0] res_dest_o
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The dual lanes split the word in two equal halves of fixed width
  if (DATA_W != 2 * sdalu_pkg::HALF_W) begin : g_bad_width
    $error("sdalu_top: data width must be twice the half width");
  end

  localparam int HW = sdalu_pkg::HALF_W;

  sdalu_pkg::sdalu_op_t op_in;
  logic [DATA_W-1:0] opnd_a_d;
  logic [DATA_W-1:0] opnd_b_d;
  logic wr_allow_d;

  logic s1_valid_q;
  sdalu_pkg::sdalu_op_t s1_op_q;
  logic [DATA_W-1:0] s1_a_q;
  logic [DATA_W-1:0] s1_b_q;
  logic s1_wr_q;
  logic [sdalu_pkg::DEST_W-1:0] s1_dest_q;

  logic [DATA_W-1:0] word_res;
  logic [HW-1:0] lo_res;
  logic [HW-1:0] hi_res;
  logic [DATA_W-1:0] res_d;

  // ---------------------------------------------------------------
  // Issue decode
  // ---------------------------------------------------------------
  assign op_in = sdalu_pkg::sdalu_op_t'(op_code_i);

  // Abs operations become the two-operand form with a zero first operand
  always_comb begin
    case (op_in)
      sdalu_pkg::OP_WORD_ABS,
      sdalu_pkg::OP_DUAL_ABS: begin
        opnd_a_d = '0;
        opnd_b_d = first_source_i;
      end
      sdalu_pkg::OP_WORD_ADD,
      sdalu_pkg::OP_DUAL_ADD: begin
        opnd_a_d = first_source_i;
        opnd_b_d = second_source_i;
      end
      default: begin
        opnd_a_d = '0;
        opnd_b_d = '0;
      end
    endcase
  end

  // A missing guard behaves as a true guard
  assign wr_allow_d = !guard_used_i ||
                      guard_value_i[sdalu_pkg::GUARD_BIT];

  // ---------------------------------------------------------------
  // Stage one: operand registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_valid_q <= 1'b0;
      s1_wr_q <= 1'b0;
    end else begin
      s1_valid_q <= op_valid_i;
      s1_wr_q <= op_valid_i && wr_allow_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_op_q <= sdalu_pkg::OP_WORD_ABS;
      s1_a_q <= sdalu_pkg::DATA_RST;
      s1_b_q <= sdalu_pkg::DATA_RST;
      s1_dest_q <= sdalu_pkg::DEST_RST;
    end else if (op_valid_i) begin
      s1_op_q <= op_in;
      s1_a_q <= opnd_a_d;
      s1_b_q <= opnd_b_d;
      s1_dest_q <= dest_sel_i;
    end
  end

  // ---------------------------------------------------------------
  // Saturating lanes
  // ---------------------------------------------------------------
  sdalu_lane #(
    .W(DATA_W)
  ) u_word_lane (
    .a_i(s1_a_q),
    .b_i(s1_b_q),
    .abs_i(s1_op_q == sdalu_pkg::OP_WORD_ABS),
    .res_o(word_res)
  );

  sdalu_lane #(
    .W(HW)
  ) u_lo_lane (
    .a_i(s1_a_q[HW-1:0]),
    .b_i(s1_b_q[HW-1:0]),
    .abs_i(s1_op_q == sdalu_pkg::OP_DUAL_ABS),
    .res_o(lo_res)
  );

  sdalu_lane #(
    .W(HW)
  ) u_hi_lane (
    .a_i(s1_a_q[DATA_W-1:HW]),
    .b_i(s1_b_q[DATA_W-1:HW]),
    .abs_i(s1_op_q == sdalu_pkg::OP_DUAL_ABS),
    .res_o(hi_res)
  );

  always_comb begin
    case (s1_op_q)
      sdalu_pkg::OP_DUAL_ABS,
      sdalu_pkg::OP_DUAL_ADD: res_d = {hi_res, lo_res};
      sdalu_pkg::OP_WORD_ABS,
      sdalu_pkg::OP_WORD_ADD: res_d = word_res;
      default: res_d = word_res;
    endcase
  end

  // ---------------------------------------------------------------
  // Stage two: result registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_valid_o <= 1'b0;
      res_wr_en_o <= 1'b0;
    end else begin
      res_valid_o <= s1_valid_q;
      res_wr_en_o <= s1_valid_q && s1_wr_q;
    end
  end

  // Data holds between results, which saves toggling on idle cycles
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_data_o <= sdalu_pkg::DATA_RST;
      res_dest_o <= sdalu_pkg::DEST_RST;
    end else if (s1_valid_q) begin
      res_data_o <= res_d;
      res_dest_o <= s1_dest_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Values sampled before reset release must not feed the checks
  logic [1:0] settle_q;
  logic settled;
  logic signed [DATA_W:0] chk_wsum;
  logic signed [HW:0] chk_lsum;
  logic signed [HW:0] chk_hsum;
  logic [HW-1:0] src_lo;
  logic [HW-1:0] src_hi;
  logic issued_wabs;
  logic issued_wadd;
  logic issued_dabs;
  logic issued_dadd;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'(sdalu_pkg::LATENCY)) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  assign settled = (settle_q == 2'(sdalu_pkg::LATENCY));
  assign chk_wsum = $signed({first_source_i[DATA_W-1], first_source_i}) +
                    $signed({second_source_i[DATA_W-1], second_source_i});
  assign chk_lsum = $signed({first_source_i[HW-1], first_source_i[HW-1:0]})
                  + $signed({second_source_i[HW-1],
                             second_source_i[HW-1:0]});
  assign chk_hsum = $signed({first_source_i[DATA_W-1],
                             first_source_i[DATA_W-1:HW]})
                  + $signed({second_source_i[DATA_W-1],
                             second_source_i[DATA_W-1:HW]});
  assign src_lo = first_source_i[HW-1:0];
  assign src_hi = first_source_i[DATA_W-1:HW];
  assign issued_wabs = op_valid_i && (op_in == sdalu_pkg::OP_WORD_ABS);
  assign issued_wadd = op_valid_i && (op_in == sdalu_pkg::OP_WORD_ADD);
  assign issued_dabs = op_valid_i && (op_in == sdalu_pkg::OP_DUAL_ABS);
  assign issued_dadd = op_valid_i && (op_in == sdalu_pkg::OP_DUAL_ADD);

  abs_pass_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wabs && !first_source_i[DATA_W-1] |->
      ##2 res_data_o == $past(first_source_i, 2))
    else $error("word abs altered a non-negative source");

  abs_negate_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wabs && first_source_i[DATA_W-1] &&
    first_source_i != sdalu_pkg::WORD_MIN |->
      ##2 res_data_o == DATA_W'(-$past(first_source_i, 2)))
    else $error("word abs did not negate a negative source");

  abs_min_clip_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wabs && first_source_i == sdalu_pkg::WORD_MIN |->
      ##2 res_data_o == sdalu_pkg::WORD_MAX)
    else $error("word abs of most negative value not clipped");

  abs_zero_opnd_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wabs |=> s1_a_q == '0 && s1_b_q == $past(first_source_i))
    else $error("word abs operands not zero and source");

  add_high_clip_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wadd && chk_wsum > $signed({1'b0, sdalu_pkg::WORD_MAX}) |->
      ##2 res_data_o == sdalu_pkg::WORD_MAX)
    else $error("word add overflow not clipped to maximum");

  add_low_clip_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wadd && chk_wsum < $signed({1'b1, sdalu_pkg::WORD_MIN}) |->
      ##2 res_data_o == sdalu_pkg::WORD_MIN)
    else $error("word add underflow not clipped to minimum");

  add_in_range_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_wadd && chk_wsum[DATA_W] == chk_wsum[DATA_W-1] |->
      ##2 res_data_o == $past(chk_wsum[DATA_W-1:0], 2))
    else $error("word add in-range sum altered");

  dual_abs_lane_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dabs && src_lo != sdalu_pkg::HALF_MIN &&
    src_hi != sdalu_pkg::HALF_MIN |->
      ##2 res_data_o[HW-1:0] == ($past(src_lo[HW-1], 2) ?
            HW'(-$past(src_lo, 2)) : $past(src_lo, 2)) &&
          res_data_o[DATA_W-1:HW] == ($past(src_hi[HW-1], 2) ?
            HW'(-$past(src_hi, 2)) : $past(src_hi, 2)))
    else $error("dual abs half magnitude wrong");

  dual_abs_min_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dabs && (src_lo == sdalu_pkg::HALF_MIN ||
                    src_hi == sdalu_pkg::HALF_MIN) |->
      ##2 (res_data_o[HW-1] == 1'b0 && res_data_o[DATA_W-1] == 1'b0) &&
          ($past(src_lo, 2) != sdalu_pkg::HALF_MIN ||
           res_data_o[HW-1:0] == sdalu_pkg::HALF_MAX) &&
          ($past(src_hi, 2) != sdalu_pkg::HALF_MIN ||
           res_data_o[DATA_W-1:HW] == sdalu_pkg::HALF_MAX))
    else $error("dual abs of most negative half not clipped");

  dual_zero_opnd_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dabs |=> s1_a_q == '0 && s1_b_q == $past(first_source_i))
    else $error("dual abs operands not zero and source");

  dual_add_low_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dadd && chk_lsum < $signed({1'b1, sdalu_pkg::HALF_MIN}) |->
      ##2 res_data_o[HW-1:0] == sdalu_pkg::HALF_MIN)
    else $error("dual add low half underflow not clipped");

  dual_add_high_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dadd && chk_hsum > $signed({1'b0, sdalu_pkg::HALF_MAX}) |->
      ##2 res_data_o[DATA_W-1:HW] == sdalu_pkg::HALF_MAX)
    else $error("dual add high half overflow not clipped");

  dual_add_place_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    issued_dadd && chk_lsum[HW] == chk_lsum[HW-1] &&
    chk_hsum[HW] == chk_hsum[HW-1] |->
      ##2 res_data_o == {$past(chk_hsum[HW-1:0], 2),
                         $past(chk_lsum[HW-1:0], 2)})
    else $error("dual add halves misplaced or altered");

  guard_write_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    settled |->
      res_wr_en_o == ($past(op_valid_i, 2) &&
                      (!$past(guard_used_i, 2) ||
                       $past(guard_value_i[sdalu_pkg::GUARD_BIT], 2))))
    else $error("write enable disagrees with guard");

  fixed_latency_a: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    settled |-> res_valid_o == $past(op_valid_i, 2) &&
      (!res_valid_o || res_dest_o == $past(dest_sel_i, 2)))
    else $error("result not two cycles after issue");

endmodule : sdalu_top

// ===== bench/sdalu_regfile_model.sv
// Register file model standing behind the saturating arithmetic unit.
// Assumes write enable, index and data are settled at the rising edge.
`timescale 1ns/100ps
module sdalu_regfile_model #(
  parameter logic [31:0] FILL_VALUE = 32'h5A5A5A5A
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [sdalu_pkg::DEST_W-1:0] wr_dest_i,
  input wire logic [31:0] wr_data_i
);
  logic [31:0] regs_q [2**sdalu_pkg::DEST_W];

  // ---------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------
  // Filled with a pattern, not zero, so a stray write of zero shows
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 2**sdalu_pkg::DEST_W; i++) begin
        regs_q[i] <= FILL_VALUE;
      end
    end else if (wr_en_i) begin
      regs_q[wr_dest_i] <= wr_data_i;
    end
  end
endmodule : sdalu_regfile_model

// ===== bench/sdalu_top_tb_top.sv
// Self-checking bench for the saturating arithmetic unit.
// Assumes the unit answers two edges after issue and never stalls.
`timescale 1ns/100ps
module sdalu_top_tb_top;
  typedef struct {
    sdalu_pkg::sdalu_op_t op;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic guard_on;
    logic [31:0] guard;
    logic [31:0] exp_data;
    logic exp_wr;
  } sdalu_row_t;
  localparam int ROWS = 18;
  localparam logic [31:0] FILL = 32'h5A5A5A5A;
  logic clk, nrst, op_valid, guard_used;
  logic [1:0] op_code;
  logic [31:0] first_source, second_source, guard_value;
  logic [6:0] dest_sel;
  logic res_valid, res_wr_en;
  logic [31:0] res_data;
  logic [6:0] res_dest;
  int fail_count = 0;
  int tests_run = 0;
  sdalu_row_t cur;
  // Some abs rows carry junk in the second source: it must be ignored
  sdalu_row_t rows [ROWS] = '{
    '{sdalu_pkg::OP_WORD_ABS, 32'hFFFFFFFF, 32'h12345678, 1'b0, 32'h0,
      32'h00000001, 1'b1},
    '{sdalu_pkg::OP_WORD_ABS, 32'h80000000, 32'h0, 1'b0, 32'h0,
      32'h7FFFFFFF, 1'b1},
    '{sdalu_pkg::OP_WORD_ABS, 32'h7FFFFFFF, 32'hFFFFFFFF, 1'b0, 32'h0,
      32'h7FFFFFFF, 1'b1},
    '{sdalu_pkg::OP_WORD_ABS, 32'h80000001, 32'h0, 1'b1, 32'hFFFFFFFE,
      32'h7FFFFFFF, 1'b0},
    '{sdalu_pkg::OP_WORD_ABS, 32'h80000001, 32'h0, 1'b1, 32'h00000001,
      32'h7FFFFFFF, 1'b1},
    '{sdalu_pkg::OP_WORD_ADD, 32'h00001200, 32'h000000FF, 1'b0, 32'h0,
      32'h000012FF, 1'b1},
    '{sdalu_pkg::OP_WORD_ADD, 32'h7FFFFFFF, 32'h00000001, 1'b0, 32'h0,
      32'h7FFFFFFF, 1'b1},
    '{sdalu_pkg::OP_WORD_ADD, 32'h80000000, 32'hFFFFFFFF, 1'b0, 32'h0,
      32'h80000000, 1'b1},
    '{sdalu_pkg::OP_WORD_ADD, 32'h80000000, 32'h7FFFFFFF, 1'b0, 32'h0,
      32'hFFFFFFFF, 1'b1},
    '{sdalu_pkg::OP_DUAL_ABS, 32'hFFFF0032, 32'h0, 1'b0, 32'h0,
      32'h00010032, 1'b1},
    '{sdalu_pkg::OP_DUAL_ABS, 32'h80008001, 32'h00010001, 1'b0, 32'h0,
      32'h7FFF7FFF, 1'b1},
    '{sdalu_pkg::OP_DUAL_ABS, 32'h0032FFFF, 32'h0, 1'b0, 32'h0,
      32'h00320001, 1'b1},
    '{sdalu_pkg::OP_DUAL_ABS, 32'h7FFFFFFF, 32'h0, 1'b0, 32'h0,
      32'h7FFF0001, 1'b1},
    '{sdalu_pkg::OP_DUAL_ADD, 32'h12340032, 32'h00010002, 1'b0, 32'h0,
      32'h12350034, 1'b1},
    '{sdalu_pkg::OP_DUAL_ADD, 32'h80000001, 32'hFFFF7FFF, 1'b0, 32'h0,
      32'h80007FFF, 1'b1},
    '{sdalu_pkg::OP_DUAL_ADD, 32'h00017FFF, 32'h7FFF7FFF, 1'b0, 32'h0,
      32'h7FFF7FFF, 1'b1},
    '{sdalu_pkg::OP_DUAL_ADD, 32'h7FFF8000, 32'h00018000, 1'b0, 32'h0,
      32'h7FFF8000, 1'b1},
    '{sdalu_pkg::OP_DUAL_ADD, 32'h12340032, 32'h00010002, 1'b1, 32'h0,
      32'h12350034, 1'b0}
  };

  // ---------------------------------------------------------------
  // Design and far side
  // ---------------------------------------------------------------
  sdalu_top #(.DATA_W(32)) u_dut (
    .core_clk_i(clk), .nrst_i(nrst), .op_valid_i(op_valid),
    .op_code_i(op_code), .first_source_i(first_source),
    .second_source_i(second_source), .guard_used_i(guard_used),
    .guard_value_i(guard_value), .dest_sel_i(dest_sel),
    .res_valid_o(res_valid), .res_wr_en_o(res_wr_en),
    .res_data_o(res_data), .res_dest_o(res_dest)
  );
  sdalu_regfile_model #(.FILL_VALUE(FILL)) u_regs (
    .core_clk_i(clk), .nrst_i(nrst), .wr_en_i(res_wr_en),
    .wr_dest_i(res_dest), .wr_data_i(res_data)
  );

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic check_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_dest(input string what, input logic [6:0] exp,
                            input logic [6:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_dest

  task automatic complete_run;
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The run needs about thirty-five cycles; two thousand leaves ample margin
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    op_valid = 1'b0;
    op_code = 2'h0;
    first_source = 32'h0;
    second_source = 32'h0;
    guard_used = 1'b0;
    guard_value = 32'h0;
    dest_sel = 7'h00;
    repeat (5) @(posedge clk);
    #1;
    check_bit("res_valid in reset", 1'b0, res_valid);
    check_word("res_data in reset", 32'h0, res_data);
    nrst = 1'b1;
    @(posedge clk);
    #1;
    // Rows issue back to back; each answer is checked two edges later
    for (int i = 0; i < ROWS + 2; i++) begin
      op_valid = (i < ROWS);
      if (i < ROWS) begin
        op_code = rows[i].op;
        first_source = rows[i].src_a;
        second_source = rows[i].src_b;
        guard_used = rows[i].guard_on;
        guard_value = rows[i].guard;
        dest_sel = 7'(i + 16);
      end
      @(posedge clk);
      #1;
      if (i >= 1 && i <= ROWS) begin
        cur = rows[i-1];
        check_bit("res_valid", 1'b1, res_valid);
        check_bit("res_wr_en", cur.exp_wr, res_wr_en);
        case (cur.op)
          sdalu_pkg::OP_WORD_ABS:
            check_word("wabs", cur.exp_data, res_data);
          sdalu_pkg::OP_WORD_ADD:
            check_word("wadd", cur.exp_data, res_data);
          sdalu_pkg::OP_DUAL_ABS:
            check_word("dabs", cur.exp_data, res_data);
          default:
            check_word("dadd", cur.exp_data, res_data);
        endcase
        check_dest("res_dest", 7'(i + 15), res_dest);
      end
    end
    // Guarded-off results must leave their register untouched
    for (int j = 0; j < ROWS; j++) begin
      cur = rows[j];
      check_word("stored", cur.exp_wr ? cur.exp_data : FILL,
                 u_regs.regs_q[j + 16]);
    end
    // Lone operation: answer on the second edge only, then data holds
    op_code = sdalu_pkg::OP_WORD_ADD;
    first_source = 32'h7FFFFFFF;
    second_source = 32'h7FFFFFFF;
    guard_used = 1'b0;
    dest_sel = 7'h55;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    first_source = 32'h80000000;
    check_bit("early res_valid", 1'b0, res_valid);
    @(posedge clk);
    #1;
    check_bit("res_valid", 1'b1, res_valid);
    check_word("res_data", 32'h7FFFFFFF, res_data);
    @(posedge clk);
    #1;
    check_bit("late res_wr_en", 1'b0, res_wr_en);
    check_word("held res_data", 32'h7FFFFFFF, res_data);
    check_dest("held res_dest", 7'h55, res_dest);
    // Reset in mid-flight drops the pending operation at once
    op_code = sdalu_pkg::OP_DUAL_ADD;
    dest_sel = 7'h2A;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    nrst = 1'b0;
    #1;
    check_word("res_data after reset", 32'h0, res_data);
    check_dest("res_dest after reset", 7'h00, res_dest);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_bit("res_valid after reset", 1'b0, res_valid);
    complete_run();
  end
endmodule : sdalu_top_tb_top
